// *** hw/temp_mon_regs.vh ***
// Register offsets, field positions, reset values and timing for the temperature monitor
`ifndef TEMP_MON_REGS_VH
`define TEMP_MON_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_LOCAL          8'h00
`define ADDR_REMOTE_HI      8'h01
`define ADDR_CFG_RD         8'h03
`define ADDR_RATE_RD        8'h04
`define ADDR_CFG_WR         8'h09
`define ADDR_RATE_WR        8'h0A
`define ADDR_REMOTE_LO      8'h10
`define REGISTER_COUNT      22

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTR_RESET           8'h00
`define VALUE_RESET         8'h00
`define FRAC_RESET          2'h0
`define CFG_RESET           8'h00
`define RATE_RESET          4'h8
`define READ_ZERO           8'h00

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_MASK_BIT        7
`define CFG_STANDBY_BIT     6
`define CFG_PIN6_BIT        5
`define CFG_RANGE_BIT       2
`define CFG_USED            8'hE4

// ----------------------------------------------------------------
// Rate field and data formats
// ----------------------------------------------------------------
`define RATE_MSB            3
`define RATE_MAX            4'hA
`define RATE_NO_AVG         4'h8
`define DIV_FULL            10'h3FF
`define BIN_MIN             8'h00
`define BIN_MAX             8'h7F
`define EXT_OFFSET          11'h040
`define EXT_MAX             11'h0FF
`define EXT_TOP             8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FASTEST_PERIOD_US   15500
`define CLK_PERIOD_NS       10
`define FASTEST_PERIOD_CYC  ((`FASTEST_PERIOD_US * 1000) / `CLK_PERIOD_NS)

`endif

// *** hw/temp_format.v ***
// Formats a signed whole-degree reading as binary or offset binary
`timescale 1ns/1ps
`default_nettype none
`include "temp_mon_regs.vh"

module temp_format (
  input  wire [9:0] temp_int,
  input  wire       extended,
  output reg  [7:0] code,
  output reg        clamped
);

  reg [10:0] shifted;

  always @* begin
    shifted = {temp_int[9], temp_int} + `EXT_OFFSET;
    code    = temp_int[7:0];
    clamped = 1'b0;
    if (extended) begin
      // Offset binary, 0 degrees reads as 0x40
      if (shifted[10]) begin
        code    = `BIN_MIN;
        clamped = 1'b1;
      end else if (shifted > `EXT_MAX) begin
        code    = `EXT_TOP;
        clamped = 1'b1;
      end else begin
        code    = shifted[7:0];
      end
    end else begin
      if (temp_int[9]) begin
        code    = `BIN_MIN;
        clamped = 1'b1;
      end else if (temp_int[8:7] != 2'b00) begin
        code    = `BIN_MAX;
        clamped = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** hw/rate_timer.v ***
// Conversion period timer multiplying the fastest period by powers of two
`timescale 1ns/1ps
`default_nettype none
`include "temp_mon_regs.vh"

module rate_timer #(
  parameter [31:0] BASE_CYCLES = `FASTEST_PERIOD_CYC
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire       run,
  input  wire [3:0] rate_code,
  output reg        period_tick
);

  reg  [31:0] base_cnt_reg;
  reg  [9:0]  div_cnt_reg;
  wire [3:0]  code_eff;
  wire [9:0]  div_limit;
  wire        base_end;

  // Reserved codes run at the fastest rate
  assign code_eff  = (rate_code > `RATE_MAX) ? `RATE_MAX : rate_code;
  assign div_limit = `DIV_FULL >> code_eff;
  assign base_end  = (base_cnt_reg == BASE_CYCLES - 32'h1);

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      base_cnt_reg <= 32'h0;
      div_cnt_reg  <= 10'h0;
      period_tick  <= 1'b0;
    end else if (!run) begin
      base_cnt_reg <= 32'h0;
      div_cnt_reg  <= 10'h0;
      period_tick  <= 1'b0;
    end else begin
      period_tick <= 1'b0;
      if (base_end) begin
        base_cnt_reg <= 32'h0;
        if (div_cnt_reg >= div_limit) begin
          div_cnt_reg <= 10'h0;
          period_tick <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 10'h1;
        end
      end else begin
        base_cnt_reg <= base_cnt_reg + 32'h1;
      end
    end
  end

endmodule
`default_nettype wire

// *** hw/temp_monitor.v ***
// Register bank of a dual-channel temperature monitor
`timescale 1ns/1ps
`default_nettype none
`include "temp_mon_regs.vh"

module temp_monitor #(
  parameter [31:0] BASE_CYCLES = `FASTEST_PERIOD_CYC
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire       wr_valid,
  input  wire       wr_first,
  input  wire [7:0] wr_data,
  input  wire       rd_req,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  input  wire       conv_done,
  input  wire [9:0] conv_local_temp,
  input  wire [9:0] conv_remote_temp,
  input  wire [1:0] conv_remote_frac,
  output reg        conv_start,
  output reg        averaging_on,
  output reg        standby_active,
  output reg        range_extended,
  output reg        alarm_mask_bit,
  output reg        pin6_function_select,
  input  wire       alarm_request,
  input  wire       second_overtemp_request,
  input  wire       overtemp_request,
  output reg        pin6_out_n,
  output reg        overtemp_out_n
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [7:0] pointer_reg;
  reg  [7:0] local_value_reg;
  reg  [7:0] remote_high_reg;
  reg  [1:0] remote_frac_reg;
  reg  [7:0] config_reg;
  reg  [3:0] rate_reg;
  reg        high_lock_reg;

  reg  [7:0] read_next;
  reg        lock_next;
  reg        conv_next;
  reg        avg_next;
  reg        pin6_next;
  reg        overtemp_next;

  wire [7:0] local_code;
  wire [7:0] remote_code;
  wire       local_clamped;
  wire       remote_clamped;
  wire       period_tick;
  wire       run;
  wire       reg_write;
  wire       ext_sel;
  wire       low_read;
  wire       high_read;
  wire       result_load;
  wire       high_load;
  wire [7:0] cfg_wr_value;
  wire [3:0] rate_wr_value;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign run       = ~config_reg[`CFG_STANDBY_BIT];
  assign ext_sel   = config_reg[`CFG_RANGE_BIT];
  assign reg_write = wr_valid & ~wr_first;

  // ----------------------------------------------------------------
  // Write values
  // ----------------------------------------------------------------
  assign cfg_wr_value  = wr_data & `CFG_USED;
  assign rate_wr_value = wr_data[`RATE_MSB:0];

  // ----------------------------------------------------------------
  // Read and load strobes
  // ----------------------------------------------------------------
  assign low_read    = rd_req & (pointer_reg == `ADDR_REMOTE_LO);
  assign high_read   = rd_req & (pointer_reg == `ADDR_REMOTE_HI);
  assign result_load = conv_done;
  assign high_load   = conv_done & ~lock_next;

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  temp_format local_fmt (
    .temp_int (conv_local_temp),
    .extended (ext_sel),
    .code     (local_code),
    .clamped  (local_clamped)
  );

  temp_format remote_fmt (
    .temp_int (conv_remote_temp),
    .extended (ext_sel),
    .code     (remote_code),
    .clamped  (remote_clamped)
  );

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  rate_timer #(
    .BASE_CYCLES (BASE_CYCLES)
  ) timer (
    .mclk        (mclk),
    .reset       (reset),
    .run         (run),
    .rate_code   (rate_reg),
    .period_tick (period_tick)
  );

  // ----------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pointer_reg <= `PTR_RESET;
    end else if (wr_valid && wr_first) begin
      pointer_reg <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and rate registers
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_reg <= `CFG_RESET;
      rate_reg   <= `RATE_RESET;
    end else if (reg_write) begin
      // Only the write addresses change state; read ports take no writes
      case (pointer_reg)
        `ADDR_CFG_WR: begin
          config_reg <= cfg_wr_value;
        end
        `ADDR_RATE_WR: begin
          rate_reg <= rate_wr_value;
        end
        default: begin
          config_reg <= config_reg;
          rate_reg   <= rate_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Temperature value registers
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      local_value_reg <= `VALUE_RESET;
    end else if (result_load) begin
      // Format follows the range bit at the moment each result lands
      local_value_reg <= local_code;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      remote_high_reg <= `VALUE_RESET;
    end else if (high_load) begin
      remote_high_reg <= remote_code;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      remote_frac_reg <= `FRAC_RESET;
    end else if (result_load) begin
      remote_frac_reg <= remote_clamped ? `FRAC_RESET : conv_remote_frac;
    end
  end

  // ----------------------------------------------------------------
  // High byte lock
  // ----------------------------------------------------------------
  always @* begin
    lock_next = high_lock_reg;
    if (low_read) begin
      lock_next = 1'b1;
    end else if (high_read) begin
      lock_next = 1'b0;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      high_lock_reg <= 1'b0;
    end else begin
      high_lock_reg <= lock_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @* begin
    case (pointer_reg)
      `ADDR_LOCAL: begin
        read_next = local_value_reg;
      end
      `ADDR_REMOTE_HI: begin
        read_next = remote_high_reg;
      end
      `ADDR_REMOTE_LO: begin
        read_next = {remote_frac_reg, 6'h00};
      end
      `ADDR_CFG_RD: begin
        read_next = config_reg;
      end
      `ADDR_RATE_RD: begin
        read_next = {4'h0, rate_reg};
      end
      `ADDR_CFG_WR: begin
        read_next = `READ_ZERO;
      end
      `ADDR_RATE_WR: begin
        read_next = `READ_ZERO;
      end
      default: begin
        // Limit, status and other registers live outside this bank
        read_next = `READ_ZERO;
      end
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data <= `READ_ZERO;
    end else if (rd_req) begin
      rd_data <= read_next;
    end
  end

  // ----------------------------------------------------------------
  // Converter control
  // ----------------------------------------------------------------
  always @* begin
    conv_next = period_tick & run;
    avg_next  = (rate_reg < `RATE_NO_AVG);
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= conv_next;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      averaging_on <= 1'b0;
    end else begin
      averaging_on <= avg_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      standby_active       <= 1'b0;
      range_extended       <= 1'b0;
      alarm_mask_bit       <= 1'b0;
      pin6_function_select <= 1'b0;
    end else begin
      standby_active       <= config_reg[`CFG_STANDBY_BIT];
      range_extended       <= ext_sel;
      alarm_mask_bit       <= config_reg[`CFG_MASK_BIT];
      pin6_function_select <= config_reg[`CFG_PIN6_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pin 6 and overtemperature outputs, live in standby
  // ----------------------------------------------------------------
  always @* begin
    overtemp_next = ~overtemp_request;
    if (config_reg[`CFG_PIN6_BIT]) begin
      pin6_next = ~second_overtemp_request;
    end else begin
      pin6_next = ~(alarm_request & ~config_reg[`CFG_MASK_BIT]);
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      overtemp_out_n <= 1'b1;
    end else begin
      overtemp_out_n <= overtemp_next;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin6_out_n <= 1'b1;
    end else begin
      pin6_out_n <= pin6_next;
    end
  end

endmodule
`default_nettype wire

// *** verif/temp_monitor_asserts.sv ***
// Port checker for the temperature monitor register bank
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_asserts #(
  parameter [31:0] BASE_CYCLES = 8
) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       wr_valid,
  input wire logic       wr_first,
  input wire logic       rd_req,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       conv_start,
  input wire logic       standby_active,
  input wire logic       range_extended,
  input wire logic       alarm_mask_bit,
  input wire logic       pin6_function_select,
  input wire logic       alarm_request,
  input wire logic       second_overtemp_request,
  input wire logic       overtemp_request,
  input wire logic       pin6_out_n,
  input wire logic       overtemp_out_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  property p_rd_pulse; rd_req |=> rd_valid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer missing");
  property p_rd_quiet; !rd_req |=> !rd_valid; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without request");
  property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_cfg_cause;
    $changed({standby_active, range_extended, alarm_mask_bit, pin6_function_select})
      |-> $past(wr_valid, 2) && !$past(wr_first, 2);
  endproperty
  a_cfg_cause: assert property (p_cfg_cause) else $error("config changed without write");
  property p_conv_gap; conv_start |=> !conv_start [*7]; endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion starts too close");
  property p_conv_standby; standby_active && $past(standby_active) |-> !conv_start; endproperty
  a_conv_standby: assert property (p_conv_standby) else $error("conversion in standby");
  property p_overtemp; 1'b1 |=> overtemp_out_n != $past(overtemp_request); endproperty
  a_overtemp: assert property (p_overtemp) else $error("overtemp pin wrong");
  property p_pin6_second;
    pin6_function_select ##1 pin6_function_select |-> pin6_out_n == !$past(second_overtemp_request);
  endproperty
  a_pin6_second: assert property (p_pin6_second) else $error("pin 6 second overtemp wrong");
  property p_pin6_alarm;
    !pin6_function_select ##1 (!pin6_function_select && $stable(alarm_mask_bit))
      |-> pin6_out_n == !($past(alarm_request) && !alarm_mask_bit);
  endproperty
  a_pin6_alarm: assert property (p_pin6_alarm) else $error("pin 6 alarm wrong");
endmodule
bind temp_monitor temp_monitor_asserts #(.BASE_CYCLES(BASE_CYCLES)) u_temp_monitor_asserts (.mclk, .reset,
  .wr_valid, .wr_first, .rd_req, .rd_data, .rd_valid, .conv_start, .standby_active, .range_extended,
  .alarm_mask_bit, .pin6_function_select, .alarm_request, .second_overtemp_request, .overtemp_request,
  .pin6_out_n, .overtemp_out_n);
`default_nettype wire

// *** verif/host_model.sv ***
// Bus host model issuing pointer, data and read requests
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output var  logic       wr_valid,
  output var  logic       wr_first,
  output var  logic [7:0] wr_data,
  output var  logic       rd_req,
  output var  logic       timed_out
);
  initial begin
    {wr_valid, wr_first, rd_req, timed_out} = 4'h0;
    wr_data = 8'hA5;
  end
  // Pointer byte, optional data byte; idle data is inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit has_d);
    wr_valid <= 1'b1;
    wr_first <= 1'b1;
    wr_data <= a;
    @(posedge mclk);
    if (has_d) begin
      wr_first <= 1'b0;
      wr_data <= d;
      @(posedge mclk);
    end
    wr_valid <= 1'b0;
    wr_data <= ~wr_data;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input bit p, output logic [7:0] q);
    int n;
    if (p) wr(a, 8'h00, 1'b0);
    rd_req <= 1'b1;
    @(posedge mclk);
    rd_req <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (rd_valid !== 1'b1 && n < 4);
    q = rd_data;
    if (rd_valid !== 1'b1) timed_out = 1'b1;
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** verif/temp_monitor_config_regs_tb.sv ***
// Self-checking bench for the temperature monitor register bank
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_config_regs_tb;
  logic        mclk, reset, wr_valid, wr_first, rd_req, rd_valid, conv_done, conv_start, averaging_on, to, lock;
  logic        standby_active, range_extended, alarm_mask_bit, pin6_function_select, pin6_out_n, overtemp_out_n;
  logic        alarm_request, second_overtemp_request, overtemp_request;
  logic [7:0]  wr_data, rd_data, q;
  logic [9:0]  conv_local_temp, conv_remote_temp;
  logic [1:0]  conv_remote_frac;
  logic [31:0] seed;
  int          fail_count, tests_run, cfg, rate, loc, rhi, rlo, n, k;
  int          temps[9] = '{-70, -55, 0, 1, 127, 128, 150, 191, 192};
  logic [7:0]  ro[5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h10};
  temp_monitor #(.BASE_CYCLES(8)) u_temp_monitor (.mclk, .reset, .wr_valid, .wr_first, .wr_data, .rd_req,
    .rd_data, .rd_valid, .conv_done, .conv_local_temp, .conv_remote_temp, .conv_remote_frac, .conv_start,
    .averaging_on, .standby_active, .range_extended, .alarm_mask_bit, .pin6_function_select, .alarm_request,
    .second_overtemp_request, .overtemp_request, .pin6_out_n, .overtemp_out_n);
  host_model u_host_model (.mclk, .rd_data, .rd_valid, .wr_valid, .wr_first, .wr_data, .rd_req, .timed_out(to));
  // ------------------------------------------------
  // Model and helpers
  // ------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int fmt(int t, bit ext);
    if (ext) t = t + 64;
    if (t < 0) return 0;
    return (t > (ext ? 255 : 127)) ? (ext ? 255 : 127) : t;
  endfunction
  function automatic logic [7:0] mdl(logic [7:0] a);
    case (a)
      8'h00: return 8'(loc);
      8'h01: return 8'(rhi);
      8'h03: return 8'(cfg);
      8'h04: return 8'(rate);
      8'h10: return 8'(rlo);
      default: return 8'h00;
    endcase
  endfunction
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdm(logic [7:0] a);
    u_host_model.rd(a, 1'b1, q);
    if (to === 1'b1) begin
      fail_count++;
      end_of_test();
    end
    chk("reg_read", mdl(a), q);
    if (a == 8'h10) lock = 1'b1;
    if (a == 8'h01) lock = 1'b0;
  endtask
  task automatic cw(logic [7:0] a, logic [7:0] d);
    u_host_model.wr(a, d, 1'b1);
    if (a == 8'h09) cfg = d & 8'hE4;
    if (a == 8'h0A) rate = d & 8'h0F;
  endtask
  task automatic conv(int tl, int tr, logic [1:0] f);
    int x;
    x = tr + (cfg[2] ? 64 : 0);
    conv_local_temp <= 10'(tl);
    conv_remote_temp <= 10'(tr);
    conv_remote_frac <= f;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    loc = fmt(tl, cfg[2]);
    if (!lock) rhi = fmt(tr, cfg[2]);
    rlo = (x < 0 || x > (cfg[2] ? 255 : 127)) ? 0 : {f, 6'h00};
    @(posedge mclk);
  endtask
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (conv_start !== 1'b1 && c < 300);
    if (c >= 300) begin
      fail_count++;
      end_of_test();
    end
  endtask
  // ------------------------------------------------
  // Stimulus
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) {alarm_request, second_overtemp_request, overtemp_request} <= reset ? 3'h0 : 3'(rnd());
  logic [2:0] req_q;
  always @(posedge mclk) req_q <= {alarm_request, second_overtemp_request, overtemp_request};
  always @(negedge mclk) begin
    if (!reset) begin
      chk("overtemp_out_n", {7'h0, ~req_q[0]}, {7'h0, overtemp_out_n});
      chk("pin6_out_n", {7'h0, cfg[5] ? ~req_q[1] : ~(req_q[2] & ~cfg[7])}, {7'h0, pin6_out_n});
    end
  end
  initial begin
    seed = 32'h701F3573;
    {reset, conv_done, lock} = 3'h4;
    {conv_local_temp, conv_remote_temp, conv_remote_frac} = 22'h000000;
    {fail_count, tests_run, cfg, rate, loc, rhi, rlo} = {32'd0, 32'd0, 32'd0, 32'd8, 96'd0};
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    u_host_model.rd(8'h00, 1'b0, q);
    chk("pointer_default", 8'h00, q);
    foreach (ro[i]) rdm(ro[i]);
    rdm(8'h09);
    rdm(8'h0A);
    repeat (6) begin
      cw(8'h09, 8'(rnd()) & 8'hE4);
      rdm(8'h03);
      chk("cfg_out", {4'h0, cfg[7], cfg[6], cfg[5], cfg[2]},
          {4'h0, alarm_mask_bit, standby_active, pin6_function_select, range_extended});
    end
    foreach (ro[i]) cw(ro[i], 8'h5A);
    foreach (ro[i]) rdm(ro[i]);
    for (int c = 0; c <= 10; c++) begin
      cw(8'h0A, 8'(c));
      rdm(8'h04);
      chk("averaging", {7'h0, c < 8}, {7'h0, averaging_on});
    end
    for (int r = 0; r < 2; r++) begin
      cw(8'h09, r ? 8'h04 : 8'h00);
      rdm(8'h04);
      foreach (temps[i]) begin
        conv(temps[i], temps[i] - r, 2'(rnd()));
        rdm(8'h00);
        rdm(8'h10);
        rdm(8'h01);
      end
    end
    conv(20, 30, 2'h1);
    rdm(8'h10);
    conv(40, 50, 2'h2);
    rdm(8'h10);
    rdm(8'h01);
    conv(60, 70, 2'h3);
    rdm(8'h01);
    for (int c = 10; c >= 8; c--) begin
      cw(8'h0A, 8'(c));
      repeat (3) gap(k);
      chk("period", 8'(8 << (10 - c)), 8'(k));
      @(posedge mclk);
    end
    cw(8'h09, 8'h40);
    n = 0;
    repeat (100) begin
      @(negedge mclk);
      if (conv_start === 1'b1) n++;
    end
    chk("standby_starts", 8'h00, 8'(n));
    @(posedge mclk);
    rdm(8'h03);
    end_of_test();
  end
endmodule
`default_nettype wire
